//--- bench/pir_far_end.sv
// pir_far_end: peripheral request sources and the core's pending latch.
// assumes the bench changes the request pattern between clock edges.
`timescale 1ns/10ps
module pir_far_end (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic [31:0] i_raise,
  input  wire logic [11:0] i_core_user_line,
  output logic      [31:0] o_src_req,
  output logic      [11:0] o_core_latch
);
  // ------------------------------------------------------------------
  // sources hold a level until the bench drops it
  // ------------------------------------------------------------------
  assign o_src_req = i_raise;

  // ------------------------------------------------------------------
  // core side keeps pending flags itself; router output is level only
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_core_latch <= 12'h000;
    end else begin
      o_core_latch <= o_core_latch | i_core_user_line;
    end
  end
endmodule : pir_far_end

//--- bench/pir_router_bench.sv
// pir_router_bench: register and routing tests for the interrupt router.
// assumes the io port answers reads two enabled edges after the request.
`timescale 1ns/10ps
module pir_router_bench;
  import pir_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  pir_io_req_s io = '0;
  pir_io_rsp_s rsp;
  logic [31:0] raise = '0;
  logic [31:0] src;
  logic [11:0] line;
  logic [11:0] latch;
  int          n_fail = 0;
  int          num_checks = 0;
  int          c;

  always #2 clk = ~clk;

  pir_router pir_router_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_io(io),
    .i_src_req(src), .o_io(rsp), .o_core_user_line(line));
  pir_far_end pir_far_end_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_raise(raise),
    .i_core_user_line(line), .o_src_req(src), .o_core_latch(latch));

  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    io = '{rd: 1'b0, wr: 1'b1, page: IO_PAGE, addr: a, wdata: d};
    @(negedge clk);
    io.wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [9:0] a, input logic [15:0] exp);
    int k;
    @(negedge clk);
    io = '{rd: 1'b1, wr: 1'b0, page: p, addr: a, wdata: 16'h0000};
    @(negedge clk);
    io.rd = 1'b0;
    // bounded wait; every page, foreign ones too, must answer
    for (k = 0; k < 4 && rsp.valid !== 1'b1; k++) @(negedge clk);
    check({15'h0000, rsp.valid}, 16'h0001);
    check(rsp.data, exp);
  endtask : rd

  task automatic src_set(input logic [31:0] v);
    @(negedge clk);
    raise = v;
    repeat (2) @(negedge clk);
  endtask : src_set

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd(IO_PAGE, MAP_BASE, MAP_RST);
    rd(IO_PAGE, MASK_LOW_OFS, 16'hFFFF);
    rd(IO_PAGE, STAT_LAST, 16'h0000);
    // every source requesting, none routed yet
    src_set(32'hFFFF_FFFF);
    check({4'h0, line}, 16'h0000);
    // walk every code through source 0, codes 0xC..0xF must stay silent
    for (c = 0; c < 16; c++) begin
      wr(MAP_BASE, {12'hFFF, 4'(c)});
      src_set(32'h0000_0001);
      check({4'h0, line}, (c < 12) ? (16'h0001 << c) : 16'h0000);
      rd(IO_PAGE, STAT_BASE + 10'(2 * (c % 12)), (c < 12) ? 16'h0001 : 16'h0000);
    end
    // sources 5 and 20 share line 3
    wr(MAP_BASE + 10'h001, 16'hFF3F);
    wr(MAP_BASE + 10'h005, 16'hFFF3);
    src_set(32'h0010_0020);
    check({4'h0, line}, 16'h0008);
    rd(IO_PAGE, STAT_BASE + 10'h006, 16'h0020);
    rd(IO_PAGE, STAT_BASE + 10'h007, 16'h0010);
    wr(MASK_HIGH_OFS, 16'hFFEF);
    rd(IO_PAGE, STAT_BASE + 10'h007, 16'h0000);
    check({4'h0, line}, 16'h0008);
    wr(MASK_LOW_OFS, 16'hFFDF);
    check({4'h0, line}, 16'h0000);
    rd(IO_PAGE, MASK_HIGH_OFS, 16'hFFEF);
    // status words ignore writes; holes and foreign pages read zero
    wr(MASK_LOW_OFS, 16'hFFFF);
    wr(STAT_BASE + 10'h006, 16'h0000);
    rd(IO_PAGE, STAT_BASE + 10'h006, 16'h0020);
    rd(IO_PAGE, 10'h3FF, 16'h0000);
    rd(8'h02, MAP_BASE + 10'h001, 16'h0000);
    // source 31 sits in the top nibble of the last map word
    wr(MAP_BASE + 10'h007, 16'hBFFF);
    src_set(32'h8000_0000);
    check({4'h0, line}, 16'h0800);
    rd(IO_PAGE, STAT_LAST, 16'h8000);
    // clock enable low freezes the line outputs, they follow again once it rises
    ce = 1'b0;
    src_set(32'h0000_0000);
    check({4'h0, line}, 16'h0800);
    ce = 1'b1;
    src_set(32'h0000_0000);
    check({4'h0, line}, 16'h0000);
    check({4'h0, latch}, 16'h0FFF);
    stop_test;
  end

  // the run needs about 250 cycles; allow far more before giving up
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
endmodule : pir_router_bench

//--- rtl/pir_map_store.sv
// pir_map_store: the eight priority-map words.
// assumes one write and one read index per cycle; read data is registered.
`timescale 1ns/10ps
module pir_map_store (
  input  wire logic                                         i_clk_sys,
  input  wire logic                                         i_rst_b,
  input  wire logic                                         i_ce,
  input  wire logic                                         i_wr,
  input  wire logic [2:0]                                   i_widx,
  input  wire logic [pir_pkg::DATA_W-1:0]                   i_wdata,
  input  wire logic [2:0]                                   i_ridx,
  output logic      [pir_pkg::DATA_W-1:0]                   o_rdata,
  output logic      [pir_pkg::NUM_MAP*pir_pkg::DATA_W-1:0]  o_map
);
  import pir_pkg::*;

  logic [DATA_W-1:0] word [NUM_MAP];

  // ------------------------------------------------------------------
  // storage, all words visible at once for routing
  // ------------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < NUM_MAP; n++) begin : g_word
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          word[n] <= MAP_RST;
        end else if (i_ce && i_wr && (i_widx == 3'(n))) begin
          word[n] <= i_wdata;
        end
      end
      assign o_map[n*DATA_W +: DATA_W] = word[n];
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rdata <= MAP_RST;
    end else if (i_ce) begin
      o_rdata <= word[i_ridx];
    end
  end

endmodule : pir_map_store

//--- rtl/pir_pkg.sv
// pir_pkg: constants and carrier types for the peripheral interrupt router.
// assumes a 16-bit io-mapped register port, one io page per peripheral.
package pir_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int unsigned NUM_SRC    = 32;
  localparam int unsigned NUM_LINE   = 12;
  localparam int unsigned NUM_MAP    = 8;
  localparam int unsigned CODE_W     = 4;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned PAGE_W     = 8;

  // ------------------------------------------------------------------
  // io map (page and word offsets)
  // ------------------------------------------------------------------
  localparam logic [PAGE_W-1:0] IO_PAGE       = 8'h01;
  localparam logic [ADDR_W-1:0] MAP_BASE      = 10'h200;
  localparam logic [ADDR_W-1:0] MASK_LOW_OFS  = 10'h208;
  localparam logic [ADDR_W-1:0] MASK_HIGH_OFS = 10'h209;
  localparam logic [ADDR_W-1:0] STAT_BASE     = 10'h210;
  localparam logic [ADDR_W-1:0] STAT_LAST     = 10'h227;

  // ------------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------------
  localparam logic [DATA_W-1:0] MAP_RST       = 16'hFFFF;
  localparam logic [DATA_W-1:0] MASK_RST      = 16'hFFFF;
  localparam logic [DATA_W-1:0] STAT_RST      = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_LAST     = 4'hB;

  // one io access, taken in a single clock
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [PAGE_W-1:0] page;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pir_io_req_s;

  // read answer
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } pir_io_rsp_s;

endpackage : pir_pkg

//--- rtl/pir_router.sv
// pir_router: routes 32 peripheral requests onto 12 core user lines.
// assumes request inputs synchronous to i_clk_sys; the core masks and latches.
`timescale 1ns/10ps

// Contract
// - up to 32 sources, each with its own 4-bit code choosing a line.
// - eight 16-bit map words, four codes each, word 0 holds sources 0..3.
// - code n from 0x0 to 0xB drives core user line n.
// - line zero has the highest priority, line eleven the lowest.
// - codes 0xC to 0xF leave the source connected to no line.
// - a line is high while any enabled source routed to it requests.
// - an unrouted source never raises any line.
// - 32-bit mask kept as a low and a high 16-bit word.
// - mask bit set passes the source, reset value is set; clear blocks it.
// - twelve read-only 32-bit status registers, writes ignored.
// - each status register read as separate low and high 16-bit words.
// - status bit k of line j is one exactly while source k drives j.
// - router only forwards requests; no latching or line masking here.
module pir_router (
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_rst_b,
  input  wire logic                             i_ce,
  input  wire pir_pkg::pir_io_req_s             i_io,
  input  wire logic [pir_pkg::NUM_SRC-1:0]      i_src_req,
  output pir_pkg::pir_io_rsp_s                  o_io,
  output logic      [pir_pkg::NUM_LINE-1:0]     o_core_user_line
);
  import pir_pkg::*;

  // ------------------------------------------------------------------
  // io decode
  // ------------------------------------------------------------------
  wire                page_hit  = (i_io.page == IO_PAGE);
  wire                sel_map   = page_hit && (i_io.addr[ADDR_W-1:3] == MAP_BASE[ADDR_W-1:3]);
  wire                sel_mlow  = page_hit && (i_io.addr == MASK_LOW_OFS);
  wire                sel_mhigh = page_hit && (i_io.addr == MASK_HIGH_OFS);
  wire                sel_stat  = page_hit && (i_io.addr >= STAT_BASE)
                                           && (i_io.addr <= STAT_LAST);
  wire [ADDR_W-1:0]   stat_ofs  = i_io.addr - STAT_BASE;
  wire [3:0]          stat_line = stat_ofs[4:1];
  wire                stat_high = stat_ofs[0];
  wire                wr_map    = i_io.wr && sel_map;
  wire                wr_mlow   = i_io.wr && sel_mlow;
  wire                wr_mhigh  = i_io.wr && sel_mhigh;

  // ------------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------------
  logic [DATA_W-1:0]             mask_low;
  logic [DATA_W-1:0]             mask_high;
  logic [NUM_MAP*DATA_W-1:0]     map_flat;
  logic [DATA_W-1:0]             map_rdata;

  // map words in their own store
  pir_map_store pir_map_store_i (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .i_wr      (wr_map),
    .i_widx    (i_io.addr[2:0]),
    .i_wdata   (i_io.wdata),
    .i_ridx    (i_io.addr[2:0]),
    .o_rdata   (map_rdata),
    .o_map     (map_flat)
  );

  // two mask words, reset to all pass
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mask_low  <= MASK_RST;
      mask_high <= MASK_RST;
    end else if (i_ce) begin
      if (wr_mlow) begin
        mask_low <= i_io.wdata;
      end
      if (wr_mhigh) begin
        mask_high <= i_io.wdata;
      end
    end
  end

  // mask bit n belongs to source n
  wire [NUM_SRC-1:0] mask_all = {mask_high, mask_low};
  // masked sources drop out before routing
  wire [NUM_SRC-1:0] src_live = i_src_req & mask_all;

  // ------------------------------------------------------------------
  // routing matrix: one row per source
  // ------------------------------------------------------------------
  logic [NUM_LINE-1:0] route   [NUM_SRC];
  logic [NUM_SRC-1:0]  stat_col[NUM_LINE];
  logic [NUM_LINE-1:0] next_line;

  genvar k, j;
  generate
    for (k = 0; k < NUM_SRC; k++) begin : g_src
      // code of source k sits in word k/4, nibble k%4
      wire [CODE_W-1:0] code = map_flat[k*CODE_W +: CODE_W];
      for (j = 0; j < NUM_LINE; j++) begin : g_line
        // code j selects line j; codes above 0xB match nothing
        // unrouted source leaves its row all zero
        assign route[k][j]    = (code == CODE_W'(j));
        // status bit: source k is driving line j now
        assign stat_col[j][k] = src_live[k] && route[k][j];
      end
    end
    for (j = 0; j < NUM_LINE; j++) begin : g_or
      // shared line is the or of its routed sources
      assign next_line[j] = |stat_col[j];
    end
  endgenerate

  // bit order of the line bus is priority order, bit 0 highest
  // the core arbitrates, the router keeps no priority of its own
  // registered only for timing, nothing latches a past request
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_core_user_line <= '0;
    end else if (i_ce) begin
      o_core_user_line <= next_line;
    end
  end

  // ------------------------------------------------------------------
  // read path: two-stage so map reads and others line up
  // ------------------------------------------------------------------
  // status words chosen by line and half
  wire [NUM_SRC-1:0] stat_sel  = (stat_line < 4'(NUM_LINE)) ? stat_col[stat_line] : '0;
  wire [DATA_W-1:0]  stat_word = stat_high ? stat_sel[NUM_SRC-1:DATA_W]
                                           : stat_sel[DATA_W-1:0];
  wire [DATA_W-1:0]  rd_other  = sel_mlow  ? mask_low  :
                                 sel_mhigh ? mask_high :
                                 sel_stat  ? stat_word : STAT_RST;

  logic              rd_pend;
  logic              rd_from_map;
  logic [DATA_W-1:0] rd_hold;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rd_pend     <= 1'b0;
      rd_from_map <= 1'b0;
      rd_hold     <= STAT_RST;
    end else if (i_ce) begin
      rd_pend     <= i_io.rd;
      rd_from_map <= i_io.rd && sel_map;
      rd_hold     <= rd_other;
    end
  end

  // status words only reach the read mux, writes to them decode to nothing
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_io <= '0;
    end else if (i_ce) begin
      o_io.valid <= rd_pend;
      o_io.data  <= !rd_pend    ? STAT_RST  :
                    rd_from_map ? map_rdata : rd_hold;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  logic [NUM_LINE-1:0] ref_line;
  always_comb begin
    ref_line = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (i_src_req[s] && mask_all[s] && (map_flat[s*CODE_W +: CODE_W] <= CODE_LAST)) begin
        ref_line[map_flat[s*CODE_W +: CODE_W]] = 1'b1;
      end
    end
  end

  // any source that reaches any line, for the mask check
  logic [NUM_SRC-1:0] drive_any;
  always_comb begin
    drive_any = '0;
    for (int l = 0; l < NUM_LINE; l++) begin
      drive_any = drive_any | stat_col[l];
    end
  end

  sequence s_map_write;
    i_ce && i_io.wr && sel_map && (i_io.addr[2:0] == 3'd0);
  endsequence
  sequence s_map_read0;
    i_ce && i_io.rd && sel_map && (i_io.addr[2:0] == 3'd0) ##1 i_ce ##1 i_ce;
  endsequence

  line_route_a: assert property (i_ce |=> o_core_user_line == $past(ref_line))
    else $error("core line does not match routed sources");

  map_write_a: assert property (s_map_write |=> map_flat[DATA_W-1:0] == $past(i_io.wdata))
    else $error("map word 0 not updated by write");

  map_read_a: assert property (s_map_read0 |-> o_io.valid
                               && o_io.data == $past(map_flat[DATA_W-1:0], 2))
    else $error("map word 0 read back wrong");

  mask_block_a: assert property ((drive_any & ~mask_all) == '0)
    else $error("masked source still drives a line");

  code_off_a: assert property ((map_flat[CODE_W-1:0] > CODE_LAST) |->
                               (stat_col[0][0] == 1'b0) && !(|route[0]))
    else $error("disconnected code still routes source 0");

  stat_bit_a: assert property ((stat_col[3][5] ==
                                (i_src_req[5] && mask_all[5] && map_flat[23:20] == 4'h3)))
    else $error("status bit 5 of line 3 wrong");

  stat_ro_a: assert property (i_ce && i_io.wr && sel_stat |=> $stable(mask_all)
                              && $stable(map_flat))
    else $error("status write changed configuration");

  stat_read_a: assert property (i_ce && i_io.rd && sel_stat
                                && !stat_high && stat_line == 4'd0
                                ##1 i_ce ##1 i_ce |-> o_io.data == $past(stat_col[0][15:0], 2))
    else $error("line 0 low status read wrong");

  no_latch_a: assert property (i_ce && (i_src_req == '0) |=> o_core_user_line == '0)
    else $error("core line held after all sources dropped");

  mask_rst_a: assert property ($rose(i_rst_b) |-> mask_all == {NUM_SRC{1'b1}})
    else $error("mask not all pass after reset");

endmodule : pir_router
